// >>> aimp_main.sv
// measure processing for four analog input channels: scan timing,
// alignment, filtering, scaling, area flags and the apb register file
// assumes samples arrive on request from the converter path, and a
// well-behaved apb master; pins are synchronous to SYS_CLK
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - above the upper threshold a value is in the overflow area and is flagged
// - below the lower threshold a value is in the underflow area and is flagged
// - between nominal maximum and upper threshold lies the upper tolerance area
// - between nominal minimum and lower threshold lies the lower tolerance area
// - upper and lower thresholds are separate writable integers per channel
// - standardized unipolar results run 0 to 10000 over the nominal range
// - standardized bipolar results run -10000 to 10000 over the nominal range
// - user format reports the lower scale limit at the range minimum
// - user format reports the upper limit at range maximum, linear between
// - user scale limits are signed 16-bit integers
// - filter output is alpha times last output plus one minus alpha times sample
// - selector 0 disables filtering, 1 to 6 raise alpha up to 0.992
// - the filter selector may be changed while running
// - filtering works in both normal and fast cycle
// - filter runs once per module cycle, 5 ms in normal mode
// - an alignment offset is added per channel; above 1500 counts it is refused
// - the alignment offset can be changed while running
// - each channel shows whether an alignment offset is applied
// - alignment leaves every other channel setting untouched
// - tolerance areas are detected whether or not overflow control is on
// - cycle lasts 5 ms normal, or 1 ms plus 1 ms per in-use channel fast
module aimp_main #(
	parameter int MS_CYCLES = aimp_pkg::AIMP_MS_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [aimp_pkg::AIMP_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic SMP_REQ,
	output logic [1:0] SMP_CHAN,
	input wire logic RAW_VALID,
	input wire logic signed [15:0] RAW_DATA,
	output logic MEAS_VALID,
	output logic [1:0] MEAS_CHAN,
	output logic signed [15:0] MEAS_DATA,
	output logic [2:0] MEAS_AREA,
	output logic MEAS_OVER,
	output logic MEAS_UNDER,
	output logic CYCLE_START
);
	import aimp_pkg::*;

	typedef enum logic [1:0] {SCAN_IDLE, SCAN_SEL, SCAN_WAIT, SCAN_STORE} aimp_scan_t;

	// configuration and per-channel storage
	logic fast_ff;
	logic [3:0] use_ff;
	logic [3:0] rej_ff;
	logic [1:0] rng_ff [AIMP_CH_N];
	logic [2:0] filt_ff [AIMP_CH_N];
	logic ovf_en_ff [AIMP_CH_N];
	logic [15:0] thr_up_ff [AIMP_CH_N];
	logic [15:0] thr_lo_ff [AIMP_CH_N];
	logic [15:0] usc_lo_ff [AIMP_CH_N];
	logic [15:0] usc_hi_ff [AIMP_CH_N];
	logic [15:0] align_ff [AIMP_CH_N];
	logic [15:0] meas_ff [AIMP_CH_N];
	logic [2:0] area_ff [AIMP_CH_N];
	logic [23:0] fstate_ff [AIMP_CH_N];
	logic [3:0] primed_ff;
	logic [31:0] prdata_ff;

	// scan and timing state
	aimp_scan_t scan_ff;
	logic [1:0] ch_ff;
	logic [31:0] ms_cnt_ff;
	logic [3:0] cyc_ms_ff;
	logic signed [15:0] filt_out_ff;
	logic meas_valid_ff;
	logic [1:0] meas_chan_ff;
	logic [15:0] meas_data_ff;
	logic [2:0] meas_area_ff;
	logic meas_over_ff;
	logic meas_under_ff;

	// apb decode
	wire logic setup = PSEL && !PENABLE;
	wire logic access = PSEL && PENABLE;
	wire logic wr = access && PWRITE;
	wire logic ch_region = (PADDR[11:7] == AIMP_CH_REGION);
	wire logic [1:0] bus_ch = PADDR[6:5];
	wire logic [4:0] ch_off = PADDR[4:0];
	wire logic hit_ctrl = (PADDR == AIMP_OFF_CTRL);
	wire logic hit_stat = (PADDR == AIMP_OFF_STAT);
	wire logic hit_cfg = ch_region && (ch_off == AIMP_OFF_CFG);
	wire logic hit_thr = ch_region && (ch_off == AIMP_OFF_THR);
	wire logic hit_usc = ch_region && (ch_off == AIMP_OFF_USC);
	wire logic hit_align = ch_region && (ch_off == AIMP_OFF_ALIGN);
	wire logic hit_meas = ch_region && (ch_off == AIMP_OFF_MEAS);
	wire logic hit_flag = ch_region && (ch_off == AIMP_OFF_FLAG);
	wire logic addr_ok = hit_ctrl || hit_stat || hit_cfg || hit_thr || hit_usc ||
		hit_align || hit_meas || hit_flag;

	// alignment bound check on the write data
	wire logic signed [15:0] align_wr = PWDATA[15:0];
	wire logic align_bad = (align_wr > AIMP_ALIGN_MAX) || (align_wr < -AIMP_ALIGN_MAX);
	wire logic align_take = wr && hit_align && !align_bad;
	wire logic align_refuse = wr && hit_align && align_bad;
	wire logic [2:0] filt_wr = PWDATA[AIMP_CFG_FILT_LSB +: 3];

	// register read mux, sampled in the setup phase
	wire logic [31:0] flag_word = {23'h0, (align_ff[bus_ch] != 16'h0),
		area_ff[bus_ch] == AREA_LO_TOL, area_ff[bus_ch] == AREA_UP_TOL,
		ovf_en_ff[bus_ch] && area_ff[bus_ch] == AREA_UNDER,
		ovf_en_ff[bus_ch] && area_ff[bus_ch] == AREA_OVER, 1'b0, area_ff[bus_ch]};
	wire logic [31:0] rd_mux = hit_ctrl ? {24'h0, use_ff, 3'h0, fast_ff} :
		hit_stat ? {28'h0, rej_ff} :
		hit_cfg ? {23'h0, ovf_en_ff[bus_ch], 1'b0, filt_ff[bus_ch], 2'h0, rng_ff[bus_ch]} :
		hit_thr ? {thr_up_ff[bus_ch], thr_lo_ff[bus_ch]} :
		hit_usc ? {usc_hi_ff[bus_ch], usc_lo_ff[bus_ch]} :
		hit_align ? {{16{align_ff[bus_ch][15]}}, align_ff[bus_ch]} :
		hit_meas ? {{16{meas_ff[bus_ch][15]}}, meas_ff[bus_ch]} :
		hit_flag ? flag_word : 32'h0;

	// module cycle: millisecond prescaler, then cycle length in ms
	wire logic ms_tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));
	wire logic [3:0] cyc_len = fast_ff ? AIMP_FAST_BASE_MS + aimp_count(use_ff) :
		AIMP_NORM_MS;
	wire logic cyc_end = ms_tick && (cyc_ms_ff >= cyc_len - 4'h1);
	wire logic [3:0] scope = fast_ff ? use_ff : 4'hF;
	wire logic last_ch = (ch_ff == 2'h3);

	// datapath for the channel being scanned
	wire logic signed [35:0] aligned_w = 36'(RAW_DATA) + 36'($signed(align_ff[ch_ff]));
	wire logic signed [15:0] aligned = aimp_sat16(aligned_w);
	wire logic signed [23:0] nxt_fstate;
	wire logic signed [15:0] filt_y;
	wire logic signed [15:0] scaled;
	wire logic [2:0] area;
	wire logic take_raw = (scan_ff == SCAN_WAIT) && RAW_VALID;

	aimp_filter u_filter (
		.x(aligned),
		.state(fstate_ff[ch_ff]),
		.sel(filt_ff[ch_ff]),
		.primed(primed_ff[ch_ff]),
		.nxt_state(nxt_fstate),
		.y(filt_y)
	);

	aimp_scale u_scale (
		.val(filt_out_ff),
		.rng(rng_ff[ch_ff]),
		.usc_lo(usc_lo_ff[ch_ff]),
		.usc_hi(usc_hi_ff[ch_ff]),
		.thr_up(thr_up_ff[ch_ff]),
		.thr_lo(thr_lo_ff[ch_ff]),
		.scaled(scaled),
		.area(area)
	);

	// scan sequencer next state
	aimp_scan_t nxt_scan;
	always_comb begin
		nxt_scan = scan_ff;
		unique case (scan_ff)
			SCAN_IDLE: if (cyc_end) nxt_scan = SCAN_SEL;
			SCAN_SEL: if (scope[ch_ff]) nxt_scan = SCAN_WAIT;
				else if (last_ch) nxt_scan = SCAN_IDLE;
			SCAN_WAIT: if (RAW_VALID) nxt_scan = SCAN_STORE;
			SCAN_STORE: nxt_scan = last_ch ? SCAN_IDLE : SCAN_SEL;
		endcase
	end

	// apb handshake; no wait states
	assign PREADY = 1'b1;
	assign PSLVERR = access && (!addr_ok || align_refuse);
	assign PRDATA = prdata_ff;
	assign SMP_REQ = (scan_ff == SCAN_SEL) && scope[ch_ff];
	assign SMP_CHAN = ch_ff;
	assign CYCLE_START = cyc_end;
	assign MEAS_VALID = meas_valid_ff;
	assign MEAS_CHAN = meas_chan_ff;
	assign MEAS_DATA = meas_data_ff;
	assign MEAS_AREA = meas_area_ff;
	assign MEAS_OVER = meas_over_ff;
	assign MEAS_UNDER = meas_under_ff;

	// global control and refusal status; a new refusal beats a clear
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			fast_ff <= 1'b0;
			use_ff <= AIMP_RST_USE;
			rej_ff <= 4'h0;
			prdata_ff <= 32'h0;
		end else begin
			if (wr && hit_ctrl) begin
				fast_ff <= PWDATA[AIMP_CTRL_FAST_BIT];
				use_ff <= PWDATA[AIMP_CTRL_USE_LSB +: 4];
			end
			rej_ff <= (rej_ff & ~((wr && hit_stat) ? PWDATA[3:0] : 4'h0)) |
				(align_refuse ? (4'h1 << bus_ch) : 4'h0);
			if (setup)
				prdata_ff <= rd_mux;
		end
	end

	// per-channel configuration; each field written only by its own register
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < AIMP_CH_N; i++) begin
				rng_ff[i] <= RNG_UNI;
				filt_ff[i] <= 3'h0;
				ovf_en_ff[i] <= 1'b1;
				thr_up_ff[i] <= AIMP_RST_THR_UP;
				thr_lo_ff[i] <= AIMP_RST_THR_LO;
				usc_lo_ff[i] <= AIMP_RST_USC_LO;
				usc_hi_ff[i] <= AIMP_RST_USC_HI;
				align_ff[i] <= 16'h0;
			end
		end else begin
			if (wr && hit_cfg) begin
				rng_ff[bus_ch] <= PWDATA[AIMP_CFG_RNG_LSB +: 2];
				filt_ff[bus_ch] <= filt_wr;
				ovf_en_ff[bus_ch] <= PWDATA[AIMP_CFG_OVF_BIT];
			end
			if (wr && hit_thr) begin
				thr_up_ff[bus_ch] <= PWDATA[AIMP_HI_LSB +: 16];
				thr_lo_ff[bus_ch] <= PWDATA[15:0];
			end
			if (wr && hit_usc) begin
				usc_hi_ff[bus_ch] <= PWDATA[AIMP_HI_LSB +: 16];
				usc_lo_ff[bus_ch] <= PWDATA[15:0];
			end
			if (align_take)
				align_ff[bus_ch] <= align_wr;
		end
	end

	// filter history; re-enabling from selector 0 drops the old history
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			primed_ff <= 4'h0;
			for (int i = 0; i < AIMP_CH_N; i++)
				fstate_ff[i] <= 24'h0;
		end else begin
			if (take_raw) begin
				fstate_ff[ch_ff] <= nxt_fstate;
				primed_ff[ch_ff] <= 1'b1;
			end
			if (wr && hit_cfg && filt_ff[bus_ch] == 3'h0 && filt_wr != 3'h0)
				primed_ff[bus_ch] <= 1'b0;
		end
	end

	// cycle timer; one filter step per scanned channel per cycle
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ms_cnt_ff <= 32'h0;
			cyc_ms_ff <= 4'h0;
		end else begin
			ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
			if (cyc_end)
				cyc_ms_ff <= 4'h0;
			else if (ms_tick)
				cyc_ms_ff <= cyc_ms_ff + 4'h1;
		end
	end

	// scan sequencer; a late converter makes the next start be skipped
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			scan_ff <= SCAN_IDLE;
			ch_ff <= 2'h0;
			filt_out_ff <= 16'sh0;
		end else begin
			scan_ff <= nxt_scan;
			if (scan_ff == SCAN_IDLE)
				ch_ff <= 2'h0;
			else if ((scan_ff == SCAN_SEL && !scope[ch_ff] && !last_ch) ||
				(scan_ff == SCAN_STORE && !last_ch))
				ch_ff <= ch_ff + 2'h1;
			if (take_raw)
				filt_out_ff <= filt_y;
		end
	end

	// results: held per channel for software, and pulsed to the application
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < AIMP_CH_N; i++) begin
				meas_ff[i] <= 16'h0;
				area_ff[i] <= AREA_NOMINAL;
			end
			meas_valid_ff <= 1'b0;
			meas_chan_ff <= 2'h0;
			meas_data_ff <= 16'h0;
			meas_area_ff <= AREA_NOMINAL;
			meas_over_ff <= 1'b0;
			meas_under_ff <= 1'b0;
		end else begin
			meas_valid_ff <= (scan_ff == SCAN_STORE);
			if (scan_ff == SCAN_STORE) begin
				meas_ff[ch_ff] <= scaled;
				area_ff[ch_ff] <= area;
				meas_chan_ff <= ch_ff;
				meas_data_ff <= scaled;
				meas_area_ff <= area;
				meas_over_ff <= ovf_en_ff[ch_ff] && (area == AREA_OVER);
				meas_under_ff <= ovf_en_ff[ch_ff] && (area == AREA_UNDER);
			end
		end
	end
endmodule : aimp_main
`default_nettype wire

// >>> aimp_pkg.sv
// constants, types and helpers for analog input measure processing
// assumes a 40 MHz system clock and a 32-bit apb register bus
package aimp_pkg;

	localparam int AIMP_CH_N = 4;
	localparam int AIMP_ADDR_W = 12;

	// register byte offsets
	localparam logic [11:0] AIMP_OFF_CTRL = 12'h000;
	localparam logic [11:0] AIMP_OFF_STAT = 12'h004;
	localparam logic [4:0] AIMP_CH_REGION = 5'h02; // paddr[11:7] of the channel blocks
	localparam logic [4:0] AIMP_OFF_CFG = 5'h00;
	localparam logic [4:0] AIMP_OFF_THR = 5'h04;
	localparam logic [4:0] AIMP_OFF_USC = 5'h08;
	localparam logic [4:0] AIMP_OFF_ALIGN = 5'h0C;
	localparam logic [4:0] AIMP_OFF_MEAS = 5'h10;
	localparam logic [4:0] AIMP_OFF_FLAG = 5'h14;

	// field positions
	localparam int AIMP_CTRL_FAST_BIT = 0;
	localparam int AIMP_CTRL_USE_LSB = 4;
	localparam int AIMP_CFG_RNG_LSB = 0;
	localparam int AIMP_CFG_FILT_LSB = 4;
	localparam int AIMP_CFG_OVF_BIT = 8;
	localparam int AIMP_HI_LSB = 16;
	localparam int AIMP_FLAG_OVER_BIT = 4;
	localparam int AIMP_FLAG_UNDER_BIT = 5;
	localparam int AIMP_FLAG_UTOL_BIT = 6;
	localparam int AIMP_FLAG_LTOL_BIT = 7;
	localparam int AIMP_FLAG_ALIGN_BIT = 8;

	// reset values
	localparam logic [3:0] AIMP_RST_USE = 4'hF;
	localparam logic [15:0] AIMP_RST_THR_UP = 16'h2AF8; // 11000
	localparam logic [15:0] AIMP_RST_THR_LO = 16'hFC18; // -1000
	localparam logic [15:0] AIMP_RST_USC_LO = 16'h0000;
	localparam logic [15:0] AIMP_RST_USC_HI = 16'h2710; // 10000

	// nominal span of standardized display
	localparam logic signed [15:0] AIMP_NOM_MAX = 16'sh2710; // +10000
	localparam logic signed [15:0] AIMP_NOM_MIN_BI = 16'shD8F0; // -10000
	localparam logic signed [15:0] AIMP_NOM_MIN_UNI = 16'sh0000;
	localparam logic signed [15:0] AIMP_ALIGN_MAX = 16'sh05DC; // 1500 counts

	// timing: one millisecond and the module cycle lengths
	localparam int AIMP_CLK_NS = 25;
	localparam int AIMP_MS_NS = 1000000;
	localparam int AIMP_MS_CYC = AIMP_MS_NS / AIMP_CLK_NS;
	localparam logic [3:0] AIMP_NORM_MS = 4'h5;
	localparam logic [3:0] AIMP_FAST_BASE_MS = 4'h1;

	// filter fixed point
	localparam int AIMP_FRAC = 8;
	localparam logic [2:0] AIMP_FILT_MAX = 3'h6;

	typedef enum logic [1:0] {RNG_UNI, RNG_BI, RNG_USER_UNI, RNG_USER_BI} aimp_range_t;
	typedef enum logic [2:0] {AREA_NOMINAL, AREA_UP_TOL, AREA_LO_TOL, AREA_OVER,
		AREA_UNDER} aimp_area_t;

	// clamp a wide signed value into 16 bits
	function automatic logic signed [15:0] aimp_sat16(input logic signed [35:0] v);
		if (v > 36'sh0_0000_7FFF)
			return 16'sh7FFF;
		else if (v < -36'sh0_0000_8000)
			return 16'sh8000;
		else
			return v[15:0];
	endfunction : aimp_sat16

	// number of channels marked in use
	function automatic logic [3:0] aimp_count(input logic [3:0] m);
		return {3'h0, m[0]} + {3'h0, m[1]} + {3'h0, m[2]} + {3'h0, m[3]};
	endfunction : aimp_count

endpackage : aimp_pkg

// >>> aimp_filter.sv
// first-order recursive filter step for one channel sample
// purely combinational; the caller holds the state per channel
`timescale 1ns/1ps
`default_nettype none
module aimp_filter (
	input wire logic signed [15:0] x,
	input wire logic signed [23:0] state,
	input wire logic [2:0] sel,
	input wire logic primed,
	output logic signed [23:0] nxt_state,
	output logic signed [15:0] y
);
	import aimp_pkg::*;

	// alpha = 1 - 2^-k, so selector 1..6 gives 0.75 .. 0.992
	wire logic [2:0] sel_c = (sel > AIMP_FILT_MAX) ? AIMP_FILT_MAX : sel;
	wire logic [3:0] k = {1'b0, sel_c} + 4'h1;
	wire logic signed [24:0] x_fix = 25'(x) <<< AIMP_FRAC;
	wire logic signed [24:0] diff = x_fix - 25'(state);
	wire logic signed [24:0] half = 25'sh1 <<< (k - 4'h1);
	wire logic signed [24:0] step = (diff + half) >>> k;
	wire logic signed [24:0] blend = 25'(state) + step;
	wire logic signed [24:0] rnd = 25'(nxt_state) + 25'sh80; // nearest integer count

	// no history yet or filtering off: the sample passes straight through
	assign nxt_state = (sel_c == 3'h0 || !primed) ? x_fix[23:0] : blend[23:0];
	assign y = aimp_sat16(36'(rnd >>> AIMP_FRAC));
endmodule : aimp_filter
`default_nettype wire

// >>> aimp_scale.sv
// area classification and rescaling of a filtered standardized value
// combinational; limits arrive already registered from the caller
`timescale 1ns/1ps
`default_nettype none
module aimp_scale (
	input wire logic signed [15:0] val,
	input wire logic [1:0] rng,
	input wire logic signed [15:0] usc_lo,
	input wire logic signed [15:0] usc_hi,
	input wire logic signed [15:0] thr_up,
	input wire logic signed [15:0] thr_lo,
	output logic signed [15:0] scaled,
	output logic [2:0] area
);
	import aimp_pkg::*;

	wire logic bipolar = (rng == RNG_BI) || (rng == RNG_USER_BI);
	wire logic user = (rng == RNG_USER_UNI) || (rng == RNG_USER_BI);
	wire logic signed [15:0] nom_min = bipolar ? AIMP_NOM_MIN_BI : AIMP_NOM_MIN_UNI;
	wire logic signed [17:0] span = 18'(AIMP_NOM_MAX) - 18'(nom_min);
	wire logic signed [17:0] rel = 18'(val) - 18'(nom_min);
	wire logic signed [17:0] ugap = 18'(usc_hi) - 18'(usc_lo);
	wire logic signed [35:0] prod = 36'(rel) * 36'(ugap);
	wire logic signed [35:0] user_val = 36'(usc_lo) + prod / 36'(span);

	// user formats map the nominal span linearly onto the user limits
	assign scaled = user ? aimp_sat16(user_val) : val;

	// threshold tests first; tolerance bands always reported
	assign area = (val > thr_up) ? AREA_OVER :
		(val < thr_lo) ? AREA_UNDER :
		(val > AIMP_NOM_MAX) ? AREA_UP_TOL :
		(val < nom_min) ? AREA_LO_TOL : AREA_NOMINAL;
endmodule : aimp_scale
`default_nettype wire

// >>> aimp_sample_src.sv
// sample source model standing in for the converter path
// assumes one request pulse per sample and a delay of at least one edge
`timescale 1ns/1ps
`default_nettype none
module aimp_sample_src (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req,
	input wire logic [1:0] chan,
	input wire logic [3:0][15:0] vals,
	input wire logic [3:0] dly,
	output logic valid,
	output logic [15:0] data
);
	logic busy_ff;
	logic [3:0] cnt_ff;
	logic [1:0] ch_ff;

	// answer after dly edges; data toggles outside the pulse so stale values never pass
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			ch_ff <= 2'h0;
			valid <= 1'b0;
			data <= 16'h0000;
		end else begin
			valid <= 1'b0;
			data <= ~data;
			if (req && !busy_ff) begin
				busy_ff <= 1'b1;
				cnt_ff <= dly;
				ch_ff <= chan;
			end else if (busy_ff && cnt_ff > 4'h1) begin
				cnt_ff <= cnt_ff - 4'h1;
			end else if (busy_ff) begin
				busy_ff <= 1'b0;
				valid <= 1'b1;
				data <= vals[ch_ff];
			end
		end
	end
endmodule : aimp_sample_src
`default_nettype wire

// >>> aimp_props.sv
// checker for the measure processing block, bound to its top module
// assumes one clock domain and the register map of the package
`timescale 1ns/1ps
`default_nettype none
module aimp_props #(
	parameter int MS_CYCLES = 40000
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [aimp_pkg::AIMP_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SMP_REQ,
	input wire logic [1:0] SMP_CHAN,
	input wire logic RAW_VALID,
	input wire logic signed [15:0] RAW_DATA,
	input wire logic MEAS_VALID,
	input wire logic [1:0] MEAS_CHAN,
	input wire logic signed [15:0] MEAS_DATA,
	input wire logic [2:0] MEAS_AREA,
	input wire logic MEAS_OVER,
	input wire logic MEAS_UNDER,
	input wire logic CYCLE_START
);
	import aimp_pkg::*;
	logic acc;
	logic mapped;
	logic align_a;
	logic big;
	logic wait_ff;
	int gap_ff;

	// access decode; channel blocks hold words up to the flag word
	assign acc = PSEL && PENABLE;
	assign mapped = PADDR == AIMP_OFF_CTRL || PADDR == AIMP_OFF_STAT ||
		(PADDR[11:7] == AIMP_CH_REGION && PADDR[4:0] <= AIMP_OFF_FLAG && PADDR[1:0] == 2'h0);
	assign align_a = PADDR[11:7] == AIMP_CH_REGION && PADDR[4:0] == AIMP_OFF_ALIGN;
	assign big = $signed(PWDATA) > 32'sh000005DC || $signed(PWDATA) < -32'sh000005DC;

	// wait state opens on a request and closes on the sample; gap counts module cycle
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wait_ff <= 1'b0;
			gap_ff <= 0;
		end else begin
			wait_ff <= SMP_REQ || (wait_ff && !RAW_VALID);
			gap_ff <= CYCLE_START ? 0 : gap_ff + 1;
		end
	end

	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);

	a_ready_high: assert property (PREADY) else $error("ready low");
	a_bad_addr: assert property (acc && !mapped |-> PSLVERR) else $error("unmapped not refused");
	a_err_access: assert property (PSLVERR |-> acc) else $error("error outside access");
	a_align_refuse: assert property (acc && PWRITE && align_a && big |-> PSLVERR)
		else $error("large offset accepted");
	a_align_accept: assert property (acc && PWRITE && align_a && !big |-> !PSLVERR)
		else $error("legal offset refused");
	a_over_area: assert property (MEAS_OVER |-> MEAS_AREA == AREA_OVER)
		else $error("overflow flag without area");
	a_under_area: assert property (MEAS_UNDER |-> MEAS_AREA == AREA_UNDER)
		else $error("underflow flag without area");
	a_area_code: assert property (MEAS_AREA <= 3'h4) else $error("bad area code");
	a_meas_timing: assert property (wait_ff && RAW_VALID |-> ##2
		MEAS_VALID && MEAS_CHAN == $past(SMP_CHAN, 2)) else $error("result late or wrong channel");
	a_meas_cause: assert property (MEAS_VALID |-> $past(RAW_VALID, 2) ##1 !MEAS_VALID)
		else $error("result without sample");
	a_chan_hold: assert property (wait_ff && !RAW_VALID |=> $stable(SMP_CHAN))
		else $error("channel moved while waiting");

	c_over: cover property (MEAS_VALID && MEAS_OVER);
	c_refuse: cover property (PSLVERR && align_a);
	c_fast: cover property (CYCLE_START && gap_ff == 3 * MS_CYCLES - 1);
endmodule : aimp_props
bind aimp_main aimp_props #(.MS_CYCLES(MS_CYCLES)) aimp_props_i (.SYS_CLK, .RST_B, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SMP_REQ, .SMP_CHAN,
	.RAW_VALID, .RAW_DATA, .MEAS_VALID, .MEAS_CHAN, .MEAS_DATA, .MEAS_AREA, .MEAS_OVER,
	.MEAS_UNDER, .CYCLE_START);
`default_nettype wire

// >>> aimp_main_bench.sv
// self-checking bench for the measure processing block
// assumes the sample source model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module aimp_main_bench;
	import aimp_pkg::*;
	localparam int MS = 20;
	logic SYS_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, SMP_REQ, RAW_VALID, MEAS_VALID, MEAS_OVER, MEAS_UNDER, CYCLE_START;
	logic [1:0] SMP_CHAN, MEAS_CHAN;
	logic signed [15:0] RAW_DATA, MEAS_DATA;
	logic [2:0] MEAS_AREA;
	logic [3:0][15:0] vals = 64'h0;
	logic [3:0] dly = 4'h1;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] e1 [1:6] = '{16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008};
	logic [15:0] e2 [1:6] = '{16'h01C0, 16'h00F0, 16'h007C, 16'h003F, 16'h0020, 16'h0010};

	aimp_main #(.MS_CYCLES(MS)) aimp_main_i (.SYS_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SMP_REQ, .SMP_CHAN, .RAW_VALID,
		.RAW_DATA, .MEAS_VALID, .MEAS_CHAN, .MEAS_DATA, .MEAS_AREA, .MEAS_OVER, .MEAS_UNDER,
		.CYCLE_START);
	aimp_sample_src aimp_sample_src_i (.clk(SYS_CLK), .rst_b(RST_B), .req(SMP_REQ),
		.chan(SMP_CHAN), .vals(vals), .dly(dly), .valid(RAW_VALID), .data(RAW_DATA));

	// 40 MHz clock
	always #12.5 SYS_CLK = ~SYS_CLK;

	function automatic logic [11:0] cha(input int c, input logic [4:0] o);
		return 12'h100 + 12'(c * 32) + {7'h00, o};
	endfunction : cha

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
		checks_done++;
		if (got !== x) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, x, got);
		end
	endtask : chk

	// one apb transfer, entered just after a rising edge; held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK); // idle edge: the next setup never re-raises psel in this step
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk("write error", {31'h0, x}, {31'h0, e});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk("read data", x, r);
		chk("read error", {31'h0, xe}, {31'h0, e});
	endtask : rd

	task automatic cyc();
		do @(negedge SYS_CLK); while (CYCLE_START !== 1'b1);
		@(posedge SYS_CLK);
	endtask : cyc

	// new raw value from the next module cycle on, then the channel's result
	task automatic one(input int ch, input logic [15:0] raw, input logic [15:0] x,
		input logic [2:0] ar, input logic [1:0] ou);
		vals[ch] <= raw;
		cyc();
		do @(negedge SYS_CLK); while (!(MEAS_VALID === 1'b1 && MEAS_CHAN === 2'(ch)));
		chk("result", {x, 11'h0, ar, ou}, {MEAS_DATA, 11'h0, MEAS_AREA, MEAS_OVER, MEAS_UNDER});
		@(posedge SYS_CLK);
	endtask : one

	// skip a settling cycle, then time one module cycle and note the scanned channels
	task automatic period(input int len, input logic [3:0] used);
		int n;
		logic [3:0] seen;
		n = 0;
		seen = 4'h0;
		cyc();
		cyc();
		do begin
			@(negedge SYS_CLK);
			n++;
			if (SMP_REQ === 1'b1) seen[SMP_CHAN] = 1'b1;
		end while (CYCLE_START !== 1'b1);
		chk("cycle length", len, n);
		chk("scanned", {28'h0, used}, {28'h0, seen});
		@(posedge SYS_CLK);
	endtask : period

	// a hang ends the run well beyond the expected length
	always @(posedge SYS_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			$display("[ERR] run length expected done seen hang");
			results();
		end
	end

	initial begin
		repeat (10) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		@(posedge SYS_CLK);
		rd(12'h000, 32'h000000F0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			rd(cha(c, AIMP_OFF_CFG), 32'h00000100, 1'b0);
			rd(cha(c, AIMP_OFF_THR), 32'h2AF8FC18, 1'b0);
			rd(cha(c, AIMP_OFF_USC), 32'h27100000, 1'b0);
		end
		rd(12'h800, 32'h0, 1'b1);
		wr(12'h118, 32'h1, 1'b1);
		period(5 * MS, 4'hF);
		one(0, 5000, 5000, 3'h0, 2'h0);
		one(1, 10000, 10000, 3'h0, 2'h0);
		one(2, 11000, 11000, 3'h1, 2'h0);
		one(3, 11001, 11001, 3'h3, 2'h2);
		one(1, -1, -1, 3'h2, 2'h0);
		one(2, -1000, -1000, 3'h2, 2'h0);
		one(3, -1001, -1001, 3'h4, 2'h1);
		// overflow control off: area codes stay, flags drop
		wr(cha(3, AIMP_OFF_CFG), 32'h0, 1'b0);
		one(3, 11001, 11001, 3'h3, 2'h0);
		one(3, 10500, 10500, 3'h1, 2'h0);
		// thresholds of one channel only
		wr(cha(1, AIMP_OFF_THR), 32'h2904FE0C, 1'b0);
		one(1, 10501, 10501, 3'h3, 2'h2);
		one(0, 10501, 10501, 3'h1, 2'h0);
		one(1, -501, -501, 3'h4, 2'h1);
		wr(cha(1, AIMP_OFF_THR), 32'h2AF8FC18, 1'b0);
		// bipolar standard, then user formats with a slow sample source
		wr(cha(2, AIMP_OFF_CFG), 32'h101, 1'b0);
		wr(cha(2, AIMP_OFF_THR), 32'h2AF8D508, 1'b0);
		one(2, -10000, -10000, 3'h0, 2'h0);
		one(2, -10500, -10500, 3'h2, 2'h0);
		one(2, -11001, -11001, 3'h4, 2'h1);
		dly <= 4'h6;
		wr(cha(3, AIMP_OFF_CFG), 32'h102, 1'b0);
		wr(cha(3, AIMP_OFF_USC), 32'h25800C80, 1'b0);
		one(3, 0, 3200, 3'h0, 2'h0);
		one(3, 10000, 9600, 3'h0, 2'h0);
		one(3, 5000, 6400, 3'h0, 2'h0);
		wr(cha(2, AIMP_OFF_CFG), 32'h103, 1'b0);
		wr(cha(2, AIMP_OFF_USC), 32'h7FFF8000, 1'b0);
		one(2, -10000, -32768, 3'h0, 2'h0);
		one(2, 10000, 32767, 3'h0, 2'h0);
		dly <= 4'h1;
		// alignment limits, refusal status and its clearing
		wr(cha(1, AIMP_OFF_ALIGN), 32'h000005DC, 1'b0);
		one(1, 1000, 2500, 3'h0, 2'h0);
		rd(cha(1, AIMP_OFF_FLAG), 32'h00000100, 1'b0);
		rd(cha(1, AIMP_OFF_CFG), 32'h00000100, 1'b0);
		wr(cha(1, AIMP_OFF_ALIGN), 32'h000005DD, 1'b1);
		wr(cha(1, AIMP_OFF_ALIGN), 32'hFFFFFA23, 1'b1);
		rd(cha(1, AIMP_OFF_ALIGN), 32'h000005DC, 1'b0);
		rd(12'h004, 32'h2, 1'b0);
		wr(12'h004, 32'h2, 1'b0);
		rd(12'h004, 32'h0, 1'b0);
		wr(cha(1, AIMP_OFF_ALIGN), 32'hFFFFFA24, 1'b0);
		one(1, 1000, -500, 3'h2, 2'h0);
		wr(cha(1, AIMP_OFF_ALIGN), 32'h0, 1'b0);
		rd(cha(1, AIMP_OFF_FLAG), 32'h00000082, 1'b0);
		// fast cycle over channels 0 and 2, filter steps on channel 0
		wr(12'h000, 32'h00000051, 1'b0);
		period(3 * MS, 4'h5);
		for (int k = 1; k <= 6; k++) begin
			wr(cha(0, AIMP_OFF_CFG), 32'h100, 1'b0);
			one(0, 0, 0, 3'h0, 2'h0);
			wr(cha(0, AIMP_OFF_CFG), 32'h100 | (32'(k) << 4), 1'b0);
			one(0, 0, 0, 3'h0, 2'h0);
			one(0, 1024, e1[k], 3'h0, 2'h0);
			one(0, 1024, e2[k], 3'h0, 2'h0);
		end
		results();
	end
endmodule : aimp_main_bench
`default_nettype wire
